// ---- tb/comm_macro_engine_asserts.sv ----
// Port assertions for the macro engine.
// Bound to comm_macro_engine from tb_top; one clock domain.
`timescale 1ns/100ps
module comm_macro_engine_asserts
    import comm_macro_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register bus
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Memory port and window
    input wire comm_macro_pkg::mem_req_t memReq,
    input wire comm_macro_pkg::mem_rsp_t memRsp,
    input wire logic intPending,
    input wire logic intWindow,
    input wire logic busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    logic [9:0] charCyc_q;
    logic lastRead_q;
    // Window and idle restart the per-character budget
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) charCyc_q <= 10'h000;
        else if (!busy || intWindow) charCyc_q <= 10'h000;
        else if (charCyc_q != 10'h3FF) charCyc_q <= charCyc_q + 10'h001;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) lastRead_q <= 1'b0;
        else if (memReq.valid && memRsp.ack) lastRead_q <= !memReq.we;
    end
    sequence memWait;
        memReq.valid && !memRsp.ack;
    endsequence
    sequence memTaken;
        memReq.valid && memRsp.ack;
    endsequence
    a_req_held: assert property (memWait |=> memReq.valid && $stable(memReq))
        else $error("memory request changed before ack");
    // A taken fetch may turn straight into its store without a gap
    a_req_drop: assert property (memTaken |=>
        !memReq.valid || $rose(memReq.we))
        else $error("memory request stayed after ack");
    a_store_order: assert property ($rose(memReq.valid && memReq.we)
        |-> lastRead_q)
        else $error("store not preceded by fetch");
    a_window_hold: assert property (intWindow && intPending |=> intWindow)
        else $error("window left while interrupt pending");
    a_window_quiet: assert property (intWindow |-> busy && !memReq.valid)
        else $error("memory traffic inside window");
    a_idle_quiet: assert property (!busy |-> !memReq.valid)
        else $error("memory request while idle");
    a_char_time: assert property (charCyc_q <= CHAR_LAST)
        else $error("character took too long");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_resp_held: assert property ($fell(s_axi_rvalid) |->
        $past(s_axi_rready))
        else $error("read answer withdrawn");
    a_bresp_held: assert property ($fell(s_axi_bvalid) |->
        $past(s_axi_bready))
        else $error("write answer withdrawn");
endmodule

// ---- tb/mem_model.sv ----
// Word memory standing in for main storage at the engine port.
// Odd byte parity; one chosen word answers with both parity bits wrong.
`timescale 1ns/100ps
module mem_model
    import comm_macro_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Engine side
    input wire comm_macro_pkg::mem_req_t memReq,
    output comm_macro_pkg::mem_rsp_t memRsp,
    // Bench controls
    input wire logic [3:0] lat,
    input wire logic [8:0] badWord
);
    logic [15:0] mem [512];
    logic [3:0] wait_q;
    logic [15:0] rd;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            memRsp <= '0;
            wait_q <= 4'h0;
        end else if (memReq.valid && !memRsp.ack && wait_q >= lat) begin
            rd = mem[memReq.addr[8:0]];
            memRsp.ack <= 1'b1;
            memRsp.rdata <= rd;
            memRsp.rpar <= {~^rd[15:8], ~^rd[7:0]} ^ {2{memReq.addr[8:0] == badWord}};
            wait_q <= 4'h0;
            if (memReq.we && memReq.be[1]) mem[memReq.addr[8:0]][15:8] <= memReq.wdata[15:8];
            if (memReq.we && memReq.be[0]) mem[memReq.addr[8:0]][7:0] <= memReq.wdata[7:0];
        end else begin
            // Data is only valid with ack; toggle it otherwise
            memRsp.ack <= 1'b0;
            memRsp.rdata <= ~memRsp.rdata;
            if (memReq.valid && !memRsp.ack) wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// ---- tb/tb_top.sv ----
// Bench for the macro engine: register bus master plus memory model.
// The program role loads context registers before each macro.
`timescale 1ns/100ps
module tb_top;
    import comm_macro_pkg::*;
    logic ref_clk, rst_n, intPending, intWindow, busy;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    mem_req_t memReq;
    mem_rsp_t memRsp;
    logic [3:0] lat;
    logic [8:0] badWord;
    logic [31:0] rv;
    logic [1:0] rsp;
    int err_total = 0;
    int n_checks = 0;
    comm_macro_engine dut (.*);
    mem_model ram (.*);

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rv, e);
    endtask
    task automatic mchk(input logic [8:0] a, input logic [15:0] e);
        chk({16'h0000, ram.mem[a]}, {16'h0000, e});
    endtask
    function automatic logic [15:0] crcStep(input logic [15:0] c,
                                           input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        return c;
    endfunction
    // Source A1 B2 C3 D4 at byte pointer 0x20, destination 0x40
    task automatic mv(input logic [15:0] op, cnt, ctl, input int slot);
        ram.mem[9'h020] = 16'h0000;
        ram.mem[9'h021] = 16'h0000;
        wr(ADDR_PC, 16'h0100);
        wr(8'h20, 16'h0020);
        wr(8'h24, 16'h0040);
        wr(8'h28, cnt);
        wr(8'h2C, ctl);
        wr(ADDR_CMD, op);
        do rd(ADDR_STATUS); while (rv[7] !== 1'b0);
        chk(rv, 32'(16 + slot));
        rchk(ADDR_EXIT, 32'(57344 + slot));
    endtask
    task automatic t_regs();
        rchk(8'h0C, 32'h0);
        wr(8'h0C, 16'hBEEF);
        chk({30'h0, rsp}, {30'h0, RESP_OKAY});
        rchk(8'h0C, 32'h0000BEEF);
        rchk(8'h60, 32'h0);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        wr(ADDR_CMD, 16'h1234);
        rd(ADDR_STATUS);
        chk({31'h0, rv[5]}, 32'h1);
    endtask
    task automatic t_acc();
        wr(8'h04, 16'h1234);
        wr(ADDR_CMD, 16'h5710);
        rchk(ADDR_ACC, 32'h1234);
        wr(ADDR_CMD, 16'h5620);
        rchk(8'h08, 32'h1234);
        wr(ADDR_CMD, 16'h5700);
        rchk(ADDR_ACC, 32'h0);
    endtask
    task automatic t_move();
        intPending <= 1'b1;
        fork
            mv(OP_MOVE, 16'h0003, 16'h0070, 10);
            begin
                while (intWindow !== 1'b1) @(posedge ref_clk);
                repeat (20) @(posedge ref_clk);
                chk({29'h0, busy, intWindow, memReq.valid}, 32'h6);
                intPending <= 1'b0;
            end
        join
        mchk(9'h020, 16'hA1B2);
        mchk(9'h021, 16'hC300);
        rchk(8'h20, 32'h23);
        rchk(8'h24, 32'h43);
        rchk(8'h28, 32'h0);
        rchk(ADDR_ACC, {16'h0, crcStep(crcStep(crcStep(16'h0, 8'hA1),
                                       8'hB2), 8'hC3)});
    endtask
    task automatic t_mask();
        wr(ADDR_CMD, 16'h5700);
        wr(8'h30, 16'hA1A1);
        wr(8'h34, 16'hC300);
        wr(8'h38, 16'hD4C3);
        mv(OP_MOVE, 16'h0001, 16'h3440, 3);
        rchk(8'h20, 32'h23);
        rchk(8'h28, 32'h1);
        rchk(ADDR_ACC, 32'h00D0);
    endtask
    task automatic t_rest();
        badWord <= 9'h010;
        mv(OP_MOVE, 16'h0001, 16'h0010, 9);
        badWord <= 9'h1FF;
        lat <= 4'h3;
        wr(8'h3C, 16'h00B2);
        mv(OP_MOVE, 16'h0004, 16'h0090, 10);
        mchk(9'h020, 16'hA1C3);
        mchk(9'h021, 16'hD400);
        rchk(8'h24, 32'h43);
        lat <= 4'h0;
        mv(OP_PACK, 16'h0002, 16'h0010, 10);
        mchk(9'h020, 16'hB2D4);
        rchk(8'h20, 32'h24);
        mv(OP_UNPACK, 16'h0002, 16'h0010, 10);
        mchk(9'h020, 16'h00A1);
        mchk(9'h021, 16'h00B2);
        rchk(8'h24, 32'h44);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (50000) @(posedge ref_clk);
        err_total++;
        print_verdict();
    end
    initial begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready, intPending} = 3'b000;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h3;
        lat = 4'h0;
        badWord = 9'h1FF;
        ram.mem[9'h010] = 16'hA1B2;
        ram.mem[9'h011] = 16'hC3D4;
        for (int k = 1; k < 12; k++) ram.mem[9'(256 + k)] = 16'(57344 + k);
        ram.mem[9'h10C] = 16'h0100;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_regs();
        t_acc();
        t_move();
        t_mask();
        t_rest();
        print_verdict();
    end
endmodule

bind comm_macro_engine comm_macro_engine_asserts chk (.*);

// ---- verilog/comm_macro_engine.sv ----
// Communication byte-move macro engine with AXI4-Lite register access.
// Assumes a word memory that answers each request with a one-cycle ack.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module comm_macro_engine #(
    parameter int MASK_COUNT = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Memory port
    output comm_macro_pkg::mem_req_t memReq,
    input wire comm_macro_pkg::mem_rsp_t memRsp,
    // Interrupt window
    input wire logic intPending,
    output logic intWindow,
    output logic busy
);
    import comm_macro_pkg::*;

    if (MASK_COUNT < 1 || MASK_COUNT > 8) begin : g_chk
        $error("MASK_COUNT must be 1 to 8");
    end

    function automatic logic [7:0] byteOf(input logic [15:0] w,
                                          input logic sel);
        byteOf = sel ? w[7:0] : w[15:8];
    endfunction

    function automatic logic [15:0] accStep(input logic [15:0] acc,
                                            input logic [7:0] b,
                                            input logic crc);
        logic [15:0] r;
        r = acc ^ {8'h00, b};
        if (crc) begin
            for (int i = 0; i < 8; i++) begin
                r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
            end
        end else begin
            r = {8'h00, acc[7:0] ^ b};
        end
        accStep = r;
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    eng_state_t state_q;
    logic [15:0] gpr_q [16];
    logic [15:0] acc_q;
    logic [14:0] pc_q;
    logic [15:0] op_q;
    logic [15:0] exit_q;
    logic [3:0] slot_q;
    logic exitValid_q;
    logic overrun_q;
    logic badOp_q;
    logic [9:0] charCyc_q;
    logic [7:0] byte_q;
    logic parErr_q;
    logic dropped_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;

    // Decoded context
    logic [15:0] srcPtr;
    logic [15:0] dstPtr;
    logic [15:0] ctl;
    logic isPack;
    logic isUnpack;
    logic [7:0] fetchByte;
    logic fetchPerr;
    logic [7:0] discardChar;
    logic fetchDrop;
    logic [15:0] cntNext;
    logic limitHit;
    logic [3:0] exitSlot;
    logic wrFire;
    logic wrGpr;
    logic cmdWr;
    logic moveGo;
    logic readAccGo;
    logic loadAccGo;
    logic [3:0] regSel;
    logic [31:0] rdMux;
    logic rdOk;

    assign srcPtr = gpr_q[SRC_REG]; // RQ20
    assign dstPtr = gpr_q[DST_REG];
    assign ctl = gpr_q[CTL_REG];
    assign isPack = op_q == OP_PACK;
    assign isUnpack = op_q == OP_UNPACK;
    // Pack reads the low byte of each one-byte source word
    assign fetchByte = byteOf(memRsp.rdata, isPack | srcPtr[0]); // RQ13 RQ17
    assign fetchPerr = ~(^{fetchByte, isPack | srcPtr[0] ?
                           memRsp.rpar[0] : memRsp.rpar[1]});
    // Mask slot 8 doubles as the discard character
    assign discardChar = gpr_q[MASK_REG + 4'h3][7:0];
    assign fetchDrop = ctl[CTL_DISCARD] && fetchByte == discardChar; // RQ12
    assign cntNext = gpr_q[CNT_REG] - 16'h0001;
    assign limitHit = ctl[CTL_SIZE] && cntNext == WORD_ZERO; // RQ18

    // Exit priority: parity, limit, lowest mask, loop
    always_comb begin
        exitSlot = SLOT_LOOP; // RQ9
        for (int n = MASK_COUNT; n >= 1; n--) begin
            if (!dropped_q && ctl[CTL_ENA_LSB + n - 1] &&
                !(n == 8 && ctl[CTL_DISCARD]) &&
                byte_q == byteOf(gpr_q[MASK_REG + 4'((n - 1) / 2)],
                                 ((n - 1) % 2) == 1)) begin
                exitSlot = 4'(n); // RQ8 RQ10
            end
        end
        if (limitHit) begin
            exitSlot = SLOT_LIMIT; // RQ7
        end
        if (parErr_q) begin
            exitSlot = SLOT_PARITY; // RQ6
        end
    end

    // Write commit and command decode
    assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wrGpr = wrFire && awAddr_q < ADDR_GPR_END &&
                   awAddr_q[1:0] == 2'h0 && state_q == S_IDLE;
    assign cmdWr = wrFire && awAddr_q == ADDR_CMD && state_q == S_IDLE;
    assign regSel = wData_q[7:4];
    assign moveGo = cmdWr && (wData_q[15:0] == OP_MOVE ||
                              wData_q[15:0] == OP_UNPACK ||
                              wData_q[15:0] == OP_PACK); // RQ1
    assign readAccGo = cmdWr && wData_q[15:8] == OP_READ_ACC &&
                       wData_q[3:0] == 4'h0; // RQ16
    assign loadAccGo = cmdWr && wData_q[15:8] == OP_LOAD_ACC &&
                       wData_q[3:0] == 4'h0; // RQ16

    always_comb begin
        rdMux = 32'h0000_0000;
        rdOk = 1'b1;
        if (s_axi_araddr < ADDR_GPR_END && s_axi_araddr[1:0] == 2'h0) begin
            rdMux = {16'h0000, gpr_q[s_axi_araddr[5:2]]};
        end else begin
            unique case (s_axi_araddr)
                ADDR_CMD: rdMux = {16'h0000, op_q};
                ADDR_PC: rdMux = {17'h0_0000, pc_q};
                ADDR_STATUS: rdMux = {24'h00_0000, busy, overrun_q,
                                      badOp_q, exitValid_q, slot_q};
                ADDR_ACC: rdMux = {16'h0000, acc_q};
                ADDR_EXIT: rdMux = {16'h0000, exit_q};
                default: rdOk = 1'b0;
            endcase
        end
    end

    // AXI write channels: each address and data captured independently
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrFire) begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= ((awAddr_q < ADDR_GPR_END &&
                                 awAddr_q[1:0] == 2'h0) ||
                                awAddr_q == ADDR_CMD ||
                                awAddr_q == ADDR_PC) ?
                               RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Sequencer and memory requests
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            memReq <= '0;
            busy <= 1'b0;
            intWindow <= 1'b0;
            op_q <= WORD_ZERO;
            pc_q <= 15'h0000;
            exit_q <= WORD_ZERO;
            slot_q <= 4'h0;
            exitValid_q <= 1'b0;
            badOp_q <= 1'b0;
            byte_q <= 8'h00;
            parErr_q <= 1'b0;
            dropped_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (wrFire && awAddr_q == ADDR_PC) begin
                        pc_q <= wData_q[14:0];
                    end
                    if (cmdWr) begin
                        op_q <= wData_q[15:0];
                        badOp_q <= !(moveGo || readAccGo || loadAccGo);
                    end
                    if (moveGo) begin
                        exitValid_q <= 1'b0;
                        busy <= 1'b1;
                        state_q <= S_FETCH;
                        memReq <= '{1'b1, 1'b0, 2'h3, srcPtr[15:1],
                                    WORD_ZERO}; // RQ3
                    end
                end
                S_FETCH: begin
                    if (memRsp.ack) begin
                        byte_q <= fetchByte;
                        parErr_q <= fetchPerr;
                        dropped_q <= fetchDrop;
                        if (fetchDrop) begin
                            memReq.valid <= 1'b0;
                            state_q <= S_EVAL; // RQ12
                        end else begin
                            state_q <= S_STORE;
                            memReq.we <= 1'b1;
                            memReq.addr <= dstPtr[15:1]; // RQ3
                            // Unpack stores one byte per word, low byte
                            memReq.be <= isUnpack ? 2'h3 :
                                         (dstPtr[0] ? 2'h1 : 2'h2); // RQ17
                            memReq.wdata <= isUnpack ?
                                {8'h00, fetchByte} :
                                {fetchByte, fetchByte}; // RQ13
                        end
                    end
                end
                S_STORE: begin
                    if (memRsp.ack) begin
                        memReq.valid <= 1'b0;
                        state_q <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    slot_q <= exitSlot;
                    state_q <= S_PARAM;
                    memReq <= '{1'b1, 1'b0, 2'h3,
                                pc_q + {11'h000, exitSlot},
                                WORD_ZERO}; // RQ19
                end
                S_PARAM: begin
                    if (memRsp.ack) begin
                        memReq.valid <= 1'b0;
                        if (slot_q == SLOT_LOOP) begin
                            pc_q <= memRsp.rdata[14:0]; // RQ9
                            intWindow <= 1'b1; // RQ14
                            state_q <= S_WINDOW;
                        end else begin
                            exit_q <= memRsp.rdata; // RQ19
                            exitValid_q <= 1'b1;
                            busy <= 1'b0;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_WINDOW: begin
                    // Hold here while the handler runs, then resume
                    if (!intPending) begin
                        intWindow <= 1'b0;
                        state_q <= S_FETCH; // RQ14
                        memReq <= '{1'b1, 1'b0, 2'h3, srcPtr[15:1],
                                    WORD_ZERO};
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Register file; moves write only the upper context registers, read-accumulator writes any register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                gpr_q[i] <= WORD_ZERO;
            end
        end else if (wrGpr) begin
            gpr_q[awAddr_q[5:2]] <= merge(gpr_q[awAddr_q[5:2]], wData_q,
                                          wStrb_q);
        end else if (readAccGo) begin
            gpr_q[regSel] <= acc_q; // RQ16
        end else if (state_q == S_EVAL) begin
            // Pack source steps a whole word per byte
            gpr_q[SRC_REG] <= srcPtr + (isPack ? 16'h0002 : 16'h0001); // RQ4 RQ15
            if (!dropped_q) begin
                gpr_q[DST_REG] <= dstPtr +
                    (isUnpack ? 16'h0002 : 16'h0001); // RQ4 RQ13
            end
            if (ctl[CTL_SIZE]) begin
                gpr_q[CNT_REG] <= cntNext; // RQ4 RQ18
            end
        end
    end

    // Check-character accumulator
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= ACC_INIT;
        end else if (loadAccGo) begin
            acc_q <= gpr_q[regSel]; // RQ16
        end else if (state_q == S_EVAL && ctl[CTL_CHECK] && !dropped_q) begin
            acc_q <= accStep(acc_q, byte_q, ctl[CTL_CRC]); // RQ11 RQ5
        end
    end

    // Per-character time watch; window time is the handler's, not ours
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            charCyc_q <= 10'h000;
            overrun_q <= 1'b0;
        end else if (moveGo) begin
            charCyc_q <= 10'h000;
            overrun_q <= 1'b0;
        end else if (state_q == S_WINDOW) begin
            charCyc_q <= 10'h000;
        end else if (busy) begin
            if (charCyc_q == CHAR_LAST) begin
                overrun_q <= 1'b1; // RQ2
            end else begin
                charCyc_q <= charCyc_q + 10'h001;
            end
        end
    end

endmodule

// ---- verilog/comm_macro_pkg.sv ----
// Constants, types and layouts shared by the communication macro engine.
// Assumes a 16-bit word memory and a 100 MHz ref_clk.
// Function
// RQ1: Decode plain, unpack and pack move opcodes.
// RQ2: Each character finishes within five microseconds.
// RQ3: Fetch from source, then store at destination.
// RQ4: Compare, accumulate, then update pointers and counter.
// RQ5: Optional functions run only when control enables.
// RQ6: Parity error exits through slot nine first.
// RQ7: Counter reaching zero exits through slot ten.
// RQ8: Mask n match exits through slot n.
// RQ9: Otherwise loop for the next byte.
// RQ10: Compare byte against up to eight masks.
// RQ11: Accumulate CRC-16 or LRC when enabled.
// RQ12: Drop every occurrence of chosen character.
// RQ13: Pack two per word, unpack one per word.
// RQ14: Interrupt window after each byte, then resume.
// RQ15: Macro context lives in upper registers only.
// RQ16: Read and load accumulator via any register.
// RQ17: Byte select 0 is MSB, 1 LSB.
// RQ18: Enforce block size limit when enabled.
// RQ19: Exit and loop words read from parameter block.
// RQ20: Program loads context registers before issuing.
package comm_macro_pkg;

    // Opcodes
    localparam logic [15:0] OP_MOVE = 16'h5000;
    localparam logic [15:0] OP_UNPACK = 16'h5200;
    localparam logic [15:0] OP_PACK = 16'h5400;
    localparam logic [7:0] OP_READ_ACC = 8'h56;
    localparam logic [7:0] OP_LOAD_ACC = 8'h57;

    // Context registers in the upper register file
    localparam logic [3:0] SRC_REG = 4'h8;
    localparam logic [3:0] DST_REG = 4'h9;
    localparam logic [3:0] CNT_REG = 4'hA;
    localparam logic [3:0] CTL_REG = 4'hB;
    localparam logic [3:0] MASK_REG = 4'hC;

    // Control word fields
    localparam int CTL_ENA_LSB = 8;
    localparam int CTL_DISCARD = 7;
    localparam int CTL_CHECK = 6;
    localparam int CTL_CRC = 5;
    localparam int CTL_SIZE = 4;

    // Parameter block slots after the opcode word
    localparam logic [3:0] SLOT_PARITY = 4'h9;
    localparam logic [3:0] SLOT_LIMIT = 4'hA;
    localparam logic [3:0] SLOT_LOOP = 4'hC;

    // Register bus byte addresses
    localparam logic [7:0] ADDR_GPR_END = 8'h40;
    localparam logic [7:0] ADDR_CMD = 8'h40;
    localparam logic [7:0] ADDR_PC = 8'h44;
    localparam logic [7:0] ADDR_STATUS = 8'h48;
    localparam logic [7:0] ADDR_ACC = 8'h4C;
    localparam logic [7:0] ADDR_EXIT = 8'h50;

    // Reset values and check polynomial
    localparam logic [15:0] ACC_INIT = 16'h0000;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CHAR_MAX_NS = 5000;
    localparam int CHAR_MAX_CYC = CHAR_MAX_NS / CLK_PERIOD_NS;
    localparam logic [9:0] CHAR_LAST = 10'(CHAR_MAX_CYC - 1);

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic valid;
        logic we;
        logic [1:0] be;
        logic [14:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
        logic [1:0] rpar;
    } mem_rsp_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_FETCH = 3'b001,
        S_STORE = 3'b010,
        S_EVAL = 3'b011,
        S_PARAM = 3'b100,
        S_WINDOW = 3'b101
    } eng_state_t;

endpackage
